// [dso_drive_seq_out.sv]
// Sequence status outputs, fault outputs and run interlock with Avalon-MM register slave
//
// The implementer's own choices: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
module dso_drive_seq_out
  import dso_pkg::*;
#(
  parameter int unsigned TICK_LEN = TICK_CYCLES
) (
  input  wire logic              i_sys_clk,
  input  wire logic              i_nrst,
  input  wire logic [ADDR_W-1:0] i_avs_address,
  input  wire logic              i_avs_read,
  input  wire logic              i_avs_write,
  input  wire logic [31:0]       i_avs_writedata,
  input  wire logic [3:0]        i_avs_byteenable,
  output logic      [31:0]       o_avs_readdata,
  output logic                   o_avs_waitrequest,
  input  wire dso_meas_s         i_meas,
  input  wire dso_fault_s        i_fault,
  input  wire logic              i_fault_rst,
  input  wire logic              i_running,
  input  wire logic              i_run_cmd,
  input  wire logic              i_dir_rev,
  input  wire logic              i_jog,
  input  wire logic              i_local,
  output logic                   o_attain_flag,
  output logic                   o_current_detect_flag,
  output logic                   o_speed_detect_a,
  output logic                   o_speed_detect_b,
  output logic                   o_zero_speed_flag,
  output logic                   o_delayed_run_out,
  output logic      [3:0]        o_error_code_outputs,
  output logic                   o_alarm_out,
  output logic                   o_run_permit,
  output logic                   o_forward_lamp,
  output logic                   o_reverse_lamp,
  output logic                   o_irq
);

  // Assert at level, release below level minus band
  function automatic logic hyst_above(logic prev, logic [15:0] v, logic [15:0] lvl,
                                      logic [15:0] band);
    logic [16:0] lo;
    lo = {1'b0, lvl} - {1'b0, band};
    if (v >= lvl) return 1'b1;
    if (lo[16] || ({1'b0, v} < lo)) return 1'b0;
    return prev;
  endfunction

  // ---------------- tick base ----------------
  logic [31:0] tick_cnt_r, tick_cnt_nxt;
  logic        tick_r, tick_nxt;
  always_comb begin
    tick_nxt     = 1'b0;
    tick_cnt_nxt = tick_cnt_r + 32'h1;
    if (tick_cnt_r >= TICK_LEN - 1) begin
      tick_cnt_nxt = 32'h0;
      tick_nxt     = 1'b1;
    end
  end
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      tick_cnt_r <= 32'h0;
      tick_r     <= 1'b0;
    end else begin
      tick_cnt_r <= tick_cnt_nxt;
      tick_r     <= tick_nxt;
    end
  end

  // ---------------- register file ----------------
  logic [15:0] cfg_r [CFG_N];
  logic [15:0] cfg_nxt [CFG_N];
  logic [7:0]  irq_r, irq_nxt, mask_r, mask_nxt, ev;
  logic [31:0] rdata_r, rdata_nxt, rd_mux, status_w;
  logic        wait_r, wait_nxt, irq_out_r, irq_out_nxt;
  logic [4:0]  idx;
  logic        req;

  assign idx = i_avs_address[6:2];
  assign req = i_avs_read | i_avs_write;

  always_comb begin
    rd_mux = 32'h0;
    if (idx < 5'(CFG_N)) rd_mux = {16'h0, cfg_r[idx]};
    else if (idx == IDX_STATUS) rd_mux = status_w;
    else if (idx == IDX_IRQ) rd_mux = {24'h0, irq_r};
    else if (idx == IDX_MASK) rd_mux = {24'h0, mask_r};
  end

  always_comb begin
    wait_nxt  = 1'b1;
    rdata_nxt = rdata_r;
    cfg_nxt   = cfg_r;
    mask_nxt  = mask_r;
    irq_nxt   = irq_r | ev;
    // First cycle of a request: capture data, answer on the next edge
    if (req && wait_r) begin
      wait_nxt  = 1'b0;
      rdata_nxt = rd_mux;
    end
    if (req && !wait_r) begin
      if (i_avs_write && idx < 5'(CFG_N)) begin
        if (i_avs_byteenable[0]) cfg_nxt[idx][7:0] = i_avs_writedata[7:0];
        if (i_avs_byteenable[1]) cfg_nxt[idx][15:8] = i_avs_writedata[15:8];
      end
      if (i_avs_write && idx == IDX_MASK && i_avs_byteenable[0])
        mask_nxt = i_avs_writedata[7:0];
      // Only bits that were returned are cleared, and a new event still wins
      if (i_avs_read && idx == IDX_IRQ)
        irq_nxt = (irq_r & ~rdata_r[7:0]) | ev;
    end
    irq_out_nxt = |(irq_nxt & mask_nxt);
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      for (int i = 0; i < CFG_N; i++) cfg_r[i] <= CFG_RESET;
      wait_r    <= 1'b1;
      rdata_r   <= 32'h0;
      irq_r     <= 8'h00;
      mask_r    <= 8'h00;
      irq_out_r <= 1'b0;
    end else begin
      cfg_r     <= cfg_nxt;
      wait_r    <= wait_nxt;
      rdata_r   <= rdata_nxt;
      irq_r     <= irq_nxt;
      mask_r    <= mask_nxt;
      irq_out_r <= irq_out_nxt;
    end
  end

  // ---------------- level detectors ----------------
  logic [4:0]  det_r, det_nxt;
  logic [15:0] fdiff;
  always_comb begin
    fdiff = (i_meas.out_freq >= i_meas.set_freq) ? i_meas.out_freq - i_meas.set_freq
                                                 : i_meas.set_freq - i_meas.out_freq;
    det_nxt[0] = (fdiff <= cfg_r[IDX_ATTAIN]);
    det_nxt[1] = hyst_above(det_r[1], i_meas.current, cfg_r[IDX_CURRENT],
                            HYST_CURRENT);
    det_nxt[2] = hyst_above(det_r[2], i_meas.out_freq, cfg_r[IDX_SPEED_A],
                            HYST_SPEED);
    det_nxt[3] = hyst_above(det_r[3], i_meas.out_freq, cfg_r[IDX_SPEED_B],
                            HYST_SPEED);
    // Zero speed is the low side: on at or below level, off above level plus band
    det_nxt[4] = det_r[4];
    if (i_meas.out_freq <= cfg_r[IDX_ZERO]) det_nxt[4] = 1'b1;
    else if ({1'b0, i_meas.out_freq} > {1'b0, cfg_r[IDX_ZERO]} + {1'b0, HYST_SPEED})
      det_nxt[4] = 1'b0;
  end
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) det_r <= 5'h00;
    else det_r <= det_nxt;
  end

  // ---------------- delayed run output ----------------
  logic        drun_r, drun_nxt;
  logic [15:0] ddly_r, ddly_nxt;
  always_comb begin
    drun_nxt = drun_r;
    ddly_nxt = ddly_r;
    if (i_running) begin
      drun_nxt = 1'b1;
      ddly_nxt = cfg_r[IDX_OFFDLY];
    end else if (drun_r) begin
      if (ddly_r == 16'h0) drun_nxt = 1'b0;
      else if (tick_r) ddly_nxt = ddly_r - 16'h1;
    end
  end
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      drun_r <= 1'b0;
      ddly_r <= 16'h0;
    end else begin
      drun_r <= drun_nxt;
      ddly_r <= ddly_nxt;
    end
  end

  // ---------------- fault outputs ----------------
  // Channels 0..3 are error code outputs, channel 4 is the alarm
  logic [4:0] fout_r;
  genvar g;
  generate
    for (g = 0; g < 5; g++) begin : g_fault
      logic        act_r, act_nxt, minor_r, minor_nxt, hit;
      logic [15:0] hold_r, hold_nxt;
      if (g < 4) begin : g_sel
        logic [9:0] sel;
        assign sel = cfg_r[IDX_FSEL0 + 5'(g)][9:0];
        assign hit = i_fault.valid && (sel[9] == i_fault.minor) &&
                     (sel[8:4] == i_fault.main_code) && (sel[3:0] == i_fault.sub_code);
      end else begin : g_any
        assign hit = i_fault.valid;
      end
      always_comb begin
        act_nxt   = act_r;
        minor_nxt = minor_r;
        hold_nxt  = hold_r;
        if (act_r && minor_r && hold_r != 16'h0 && tick_r) begin
          hold_nxt = hold_r - 16'h1;
          if (hold_r == 16'h1) act_nxt = 1'b0;
        end
        if (i_fault_rst) act_nxt = 1'b0;
        if (hit) begin
          act_nxt   = 1'b1;
          minor_nxt = i_fault.minor;
          hold_nxt  = cfg_r[IDX_HOLD0 + 5'(g)];
        end
      end
      always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
          act_r   <= 1'b0;
          minor_r <= 1'b0;
          hold_r  <= 16'h0;
        end else begin
          act_r   <= act_nxt;
          minor_r <= minor_nxt;
          hold_r  <= hold_nxt;
        end
      end
      assign fout_r[g] = act_r;
    end
  endgenerate

  // ---------------- run interlock ----------------
  dso_run_e    run_r, run_nxt;
  logic        thr_ok_r, thr_ok_nxt, held_r, held_nxt, permit_r, permit_nxt;
  logic [15:0] rdly_r, rdly_nxt;
  logic        ilk_block;
  logic [16:0] thr_lo;
  always_comb begin
    thr_lo     = {1'b0, cfg_r[IDX_THRESH]} - {1'b0, cfg_r[IDX_THHYST]};
    thr_ok_nxt = thr_ok_r;
    if (cfg_r[IDX_THRESH] == 16'h0) thr_ok_nxt = 1'b1;
    else if (i_meas.set_freq > cfg_r[IDX_THRESH]) thr_ok_nxt = 1'b1;
    else if (thr_lo[16] || {1'b0, i_meas.set_freq} < thr_lo) thr_ok_nxt = 1'b0;
    // Only a start is inhibited; a running motor keeps going
    ilk_block = (cfg_r[IDX_ILOCK] != 16'h0) &&
                (i_meas.set_freq > cfg_r[IDX_ILOCK]);
    run_nxt  = run_r;
    rdly_nxt = rdly_r;
    unique case (run_r)
      DSO_IDLE: begin
        if (i_run_cmd && !ilk_block) begin
          run_nxt  = DSO_DELAY;
          rdly_nxt = cfg_r[IDX_RUNDLY];
        end
      end
      DSO_DELAY: begin
        if (!i_run_cmd) run_nxt = DSO_IDLE;
        else if (rdly_r == 16'h0 || i_local) run_nxt = DSO_RUN;
        else if (tick_r) rdly_nxt = rdly_r - 16'h1;
      end
      DSO_RUN: begin
        if (!i_run_cmd) run_nxt = DSO_IDLE;
      end
    endcase
    permit_nxt = i_run_cmd &&
                 (i_jog || (run_r == DSO_RUN && thr_ok_r));
    held_nxt   = i_run_cmd && !i_jog && !permit_nxt;
  end
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      run_r    <= DSO_IDLE;
      rdly_r   <= 16'h0;
      thr_ok_r <= 1'b0;
      held_r   <= 1'b0;
      permit_r <= 1'b0;
    end else begin
      run_r    <= run_nxt;
      rdly_r   <= rdly_nxt;
      thr_ok_r <= thr_ok_nxt;
      held_r   <= held_nxt;
      permit_r <= permit_nxt;
    end
  end

  // ---------------- lamps ----------------
  logic [7:0] blink_cnt_r, blink_cnt_nxt;
  logic       blink_r, blink_nxt, fwd_r, fwd_nxt, rev_r, rev_nxt;
  always_comb begin
    blink_cnt_nxt = blink_cnt_r;
    blink_nxt     = blink_r;
    if (tick_r) begin
      if (blink_cnt_r >= 8'(BLINK_TICKS - 1)) begin
        blink_cnt_nxt = 8'h00;
        blink_nxt     = ~blink_r;
      end else begin
        blink_cnt_nxt = blink_cnt_r + 8'h01;
      end
    end
    if (held_r) begin
      fwd_nxt = blink_r;
      rev_nxt = blink_r;
    end else begin
      fwd_nxt = i_running && !i_dir_rev;
      rev_nxt = i_running && i_dir_rev;
    end
  end
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      blink_cnt_r <= 8'h00;
      blink_r     <= 1'b0;
      fwd_r       <= 1'b0;
      rev_r       <= 1'b0;
    end else begin
      blink_cnt_r <= blink_cnt_nxt;
      blink_r     <= blink_nxt;
      fwd_r       <= fwd_nxt;
      rev_r       <= rev_nxt;
    end
  end

  // ---------------- events and status ----------------
  logic [4:0] det_d_r;
  logic       drun_d_r, held_d_r;
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      det_d_r  <= 5'h00;
      drun_d_r <= 1'b0;
      held_d_r <= 1'b0;
    end else begin
      det_d_r  <= det_r;
      drun_d_r <= drun_r;
      held_d_r <= held_r;
    end
  end
  assign ev = {held_r & ~held_d_r, i_fault.valid, drun_d_r & ~drun_r,
               det_r & ~det_d_r};
  assign status_w = {19'h0, fout_r, held_r, permit_r, drun_r, det_r};

  assign o_avs_readdata        = rdata_r;
  assign o_avs_waitrequest     = wait_r;
  assign o_attain_flag         = det_r[0];
  assign o_current_detect_flag = det_r[1];
  assign o_speed_detect_a      = det_r[2];
  assign o_speed_detect_b      = det_r[3];
  assign o_zero_speed_flag     = det_r[4];
  assign o_delayed_run_out     = drun_r;
  assign o_error_code_outputs  = fout_r[3:0];
  assign o_alarm_out           = fout_r[4];
  assign o_run_permit          = permit_r;
  assign o_forward_lamp        = fwd_r;
  assign o_reverse_lamp        = rev_r;
  assign o_irq                 = irq_out_r;

endmodule // dso_drive_seq_out

// [dso_pkg.sv]
// Constants, register map and carrier types for the drive sequence output interlock
// How it works
// - Attain flag set while output is within configured width of the setting.
// - Current detect compares current to level with 5% rated-current hysteresis.
// - Two speed detectors compare frequency to own levels with 1% hysteresis.
// - Zero speed flag compares frequency to its level with 1% hysteresis.
// - Delayed run output falls a configured number of 0.1 s ticks after running.
// - Running returning during the delay keeps output on; next loss restarts delay.
// - Reset, standing for power-down, clears delayed run output and its pending delay.
// - Each error output matches a fault main code 0x00-0x13 and sub-code 0x0-0xF.
// - Fault selector carries class bit: 0 major fault, 1 minor fault.
// - Minor fault outputs hold for configured time; zero holds until fault reset.
// - With threshold set, run starts once setting exceeds threshold, stops below threshold minus its hysteresis.
// - Setting above interlock value at run command inhibits motor start.
// - Interlock value zero disables interlock; zero also disables threshold and delay.
// - Motor start is delayed by the run delay time after run command.
// - Threshold, interlock and run delay are bypassed in jogging mode.
// - Run delay is bypassed in local mode.
// - While run is held back, forward and reverse lamps both flash.
package dso_pkg;

  localparam int unsigned CLK_HZ       = 200_000_000;
  localparam int unsigned TICK_MS      = 100;
  localparam int unsigned TICK_CYCLES  = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned BLINK_TICKS  = 5;

  // Quantities are in 0.1 % steps of the full scale
  localparam logic [15:0] HYST_CURRENT = 16'h0032;
  localparam logic [15:0] HYST_SPEED   = 16'h000a;

  localparam int unsigned ADDR_W = 7;
  localparam int unsigned CFG_N  = 19;
  localparam logic [4:0] IDX_ATTAIN   = 5'h00;
  localparam logic [4:0] IDX_CURRENT  = 5'h01;
  localparam logic [4:0] IDX_SPEED_A  = 5'h02;
  localparam logic [4:0] IDX_SPEED_B  = 5'h03;
  localparam logic [4:0] IDX_ZERO     = 5'h04;
  localparam logic [4:0] IDX_OFFDLY   = 5'h05;
  localparam logic [4:0] IDX_THRESH   = 5'h06;
  localparam logic [4:0] IDX_THHYST   = 5'h07;
  localparam logic [4:0] IDX_ILOCK    = 5'h08;
  localparam logic [4:0] IDX_RUNDLY   = 5'h09;
  localparam logic [4:0] IDX_FSEL0    = 5'h0a;
  localparam logic [4:0] IDX_HOLD0    = 5'h0e;
  localparam logic [4:0] IDX_STATUS   = 5'h13;
  localparam logic [4:0] IDX_IRQ      = 5'h14;
  localparam logic [4:0] IDX_MASK     = 5'h15;
  localparam logic [15:0] CFG_RESET   = 16'h0000;

  typedef struct packed {
    logic [15:0] out_freq;
    logic [15:0] set_freq;
    logic [15:0] current;
  } dso_meas_s;

  typedef struct packed {
    logic       valid;
    logic       minor;
    logic [4:0] main_code;
    logic [3:0] sub_code;
  } dso_fault_s;

  typedef enum logic [1:0] {
    DSO_IDLE  = 2'b00,
    DSO_DELAY = 2'b01,
    DSO_RUN   = 2'b11
  } dso_run_e;

endpackage

// [dso_asserts.sv]
// Port-level checker for the drive sequence output block
`timescale 1ns/1ps
module dso_asserts
  import dso_pkg::*;
(
  input wire logic              i_sys_clk,
  input wire logic              i_nrst,
  input wire logic [ADDR_W-1:0] i_avs_address,
  input wire logic              i_avs_read,
  input wire logic              i_avs_write,
  input wire logic [31:0]       i_avs_writedata,
  input wire logic [3:0]        i_avs_byteenable,
  input wire logic              o_avs_waitrequest,
  input wire dso_meas_s         i_meas,
  input wire dso_fault_s        i_fault,
  input wire logic              i_fault_rst,
  input wire logic              i_running,
  input wire logic              i_run_cmd,
  input wire logic              i_jog,
  input wire logic              o_current_detect_flag,
  input wire logic              o_delayed_run_out,
  input wire logic [3:0]        o_error_code_outputs,
  input wire logic              o_run_permit,
  input wire logic              o_forward_lamp,
  input wire logic              o_reverse_lamp
);
  // Shadow of the current level, so the detector can be judged at the ports
  logic [15:0] cur_lvl_r;
  logic [15:0] cur_lvl_nxt;

  always_comb begin
    cur_lvl_nxt = cur_lvl_r;
    for (int b = 0; b < 2; b++) begin
      if (i_avs_write && !o_avs_waitrequest && i_avs_byteenable[b] &&
          i_avs_address[6:2] == IDX_CURRENT) begin
        cur_lvl_nxt[b*8+:8] = i_avs_writedata[b*8+:8];
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) cur_lvl_r <= 16'h0000;
    else cur_lvl_r <= cur_lvl_nxt;
  end

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);

  sequence s_req;
    (i_avs_read || i_avs_write) && o_avs_waitrequest;
  endsequence
  sequence s_held;
    (i_run_cmd && !i_jog && !o_run_permit) [*3];
  endsequence

  a_bus_answer: assert property (s_req |=> !o_avs_waitrequest ##1 o_avs_waitrequest)
    else $error("bus answer is not a single cycle");
  a_cur_on: assert property (i_meas.current >= cur_lvl_r |=> o_current_detect_flag)
    else $error("current flag missing at level");
  a_cur_off: assert property (
    {1'b0, i_meas.current} + {1'b0, HYST_CURRENT} < {1'b0, cur_lvl_r} |=>
    !o_current_detect_flag)
    else $error("current flag stuck below band");
  a_drun_on: assert property ($rose(i_running) |=> o_delayed_run_out)
    else $error("delayed run did not follow running");
  a_jog_bypass: assert property (i_run_cmd && i_jog |=> o_run_permit)
    else $error("jog run not permitted at once");
  a_no_cmd: assert property (!i_run_cmd |=> !o_run_permit)
    else $error("permit without run command");
  a_lamps_flash: assert property (s_held |-> o_forward_lamp == o_reverse_lamp)
    else $error("lamps differ while run held");
  a_fault_clear: assert property (
    i_fault_rst && !i_fault.valid |=> o_error_code_outputs == 4'h0)
    else $error("fault reset did not clear outputs");
endmodule // dso_asserts

// [dso_machine.sv]
// Driven machinery model: reports running a short spin-up after the permit
`timescale 1ns/1ps
module dso_machine (
  input  wire logic i_sys_clk,
  input  wire logic i_nrst,
  input  wire logic i_run_permit,
  output logic      o_running
);
  logic [1:0] spin_r;

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) spin_r <= 2'h0;
    else spin_r <= {spin_r[0], i_run_permit};
  end
  assign o_running = spin_r[1];
endmodule // dso_machine

// [dso_tb.sv]
// Self-checking testbench for the drive sequence output block
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin miscompares++; \
  $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
module tb
  import dso_pkg::*;
;
  logic        clk, nrst, rd, wrt, fault_rst, run_cmd, jog, local_md, wait_req;
  logic        running, drun, permit, forward_lamp, reverse_lamp, alarm_out, irq, pv;
  logic [6:0]  adr;
  logic [31:0] wdat, rdata, q;
  logic [3:0]  ec;
  logic [4:0]  flags;
  logic [5:0]  mon;
  dso_meas_s   meas;
  dso_fault_s  fault;
  int          compares, miscompares, n, cnt;

  assign mon = {forward_lamp, ec[1], ec[0], irq, drun, permit};

  dso_drive_seq_out #(.TICK_LEN(10)) u_dut (
    .i_sys_clk(clk), .i_nrst(nrst), .i_avs_address(adr), .i_avs_read(rd),
    .i_avs_write(wrt), .i_avs_writedata(wdat), .i_avs_byteenable(4'hf),
    .o_avs_readdata(rdata), .o_avs_waitrequest(wait_req), .i_meas(meas), .i_fault(fault),
    .i_fault_rst(fault_rst), .i_running(running), .i_run_cmd(run_cmd), .i_dir_rev(1'b0),
    .i_jog(jog), .i_local(local_md), .o_attain_flag(flags[4]),
    .o_current_detect_flag(flags[3]), .o_speed_detect_a(flags[2]),
    .o_speed_detect_b(flags[1]), .o_zero_speed_flag(flags[0]), .o_delayed_run_out(drun),
    .o_error_code_outputs(ec), .o_alarm_out(alarm_out), .o_run_permit(permit),
    .o_forward_lamp(forward_lamp), .o_reverse_lamp(reverse_lamp), .o_irq(irq));

  dso_machine u_mach (.i_sys_clk(clk), .i_nrst(nrst), .i_run_permit(permit),
    .o_running(running));

  task automatic finish_test();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Holds the request until waitrequest is seen low, then releases it
  task automatic bus(input logic w, input logic [6:0] a, input logic [15:0] d);
    int k;
    k = 0;
    adr <= a;
    wdat <= {16'h0000, d};
    wrt <= w;
    rd <= !w;
    do begin
      @(posedge clk);
      k++;
    end while (wait_req !== 1'b0 && k < 20);
    q = rdata;
    wrt <= 1'b0;
    rd <= 1'b0;
    if (wait_req !== 1'b0) begin
      miscompares++;
      finish_test();
    end
    @(posedge clk);
  endtask

  task automatic rdc(input logic [6:0] a, input logic [31:0] e);
    bus(1'b0, a, 16'h0000);
    `CHK(q, e)
  endtask

  task automatic step(input logic [15:0] o, s, c, input int i, input logic e);
    meas <= '{out_freq: o, set_freq: s, current: c};
    repeat (2) @(posedge clk);
    `CHK(flags[i], e)
  endtask

  task automatic wt(input int i, input logic v, input int lim);
    n = 0;
    while (mon[i] !== v && n < lim) begin
      @(posedge clk);
      n++;
    end
    `CHK(mon[i], v)
    if (mon[i] !== v) finish_test();
  endtask

  task automatic pulse(input logic mi, input logic [4:0] mc, input logic [3:0] sc);
    fault <= '{valid: 1'b1, minor: mi, main_code: mc, sub_code: sc};
    @(posedge clk);
    fault.valid <= 1'b0;
    @(posedge clk);
  endtask

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    {nrst, rd, wrt, fault_rst, run_cmd, jog, local_md} = '0;
    adr = '0;
    wdat = '0;
    meas = '0;
    fault = '0;
    compares = 0;
    miscompares = 0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rdc(7'h04, 32'h0);
    rdc(7'h54, 32'h0);
    rdc(7'h7c, 32'h0);
    bus(1'b1, 7'h00, 16'd50);
    bus(1'b1, 7'h04, 16'd500);
    bus(1'b1, 7'h08, 16'd300);
    bus(1'b1, 7'h0c, 16'd600);
    bus(1'b1, 7'h10, 16'd20);
    step(0, 1000, 500, 3, 1'b1);
    step(0, 1000, 451, 3, 1'b1);
    step(0, 1000, 449, 3, 1'b0);
    step(0, 1000, 499, 3, 1'b0);
    step(300, 1000, 0, 2, 1'b1);
    step(291, 1000, 0, 2, 1'b1);
    step(289, 1000, 0, 2, 1'b0);
    step(600, 1000, 0, 1, 1'b1);
    step(589, 1000, 0, 1, 1'b0);
    step(20, 1000, 0, 0, 1'b1);
    step(30, 1000, 0, 0, 1'b1);
    step(31, 1000, 0, 0, 1'b0);
    step(950, 1000, 0, 4, 1'b1);
    step(1051, 1000, 0, 4, 1'b0);
    // Off delay of three ticks, restarted by a run in mid-delay
    bus(1'b1, 7'h14, 16'd3);
    run_cmd <= 1'b1;
    wt(1, 1'b1, 20);
    run_cmd <= 1'b0;
    wt(1, 1'b0, 60);
    `CHK(n >= 20 && n <= 50, 1'b1)
    run_cmd <= 1'b1;
    wt(1, 1'b1, 20);
    run_cmd <= 1'b0;
    repeat (15) @(posedge clk);
    run_cmd <= 1'b1;
    repeat (40) @(posedge clk);
    `CHK(mon[1], 1'b1)
    run_cmd <= 1'b0;
    wt(1, 1'b0, 60);
    `CHK(n >= 20 && n <= 50, 1'b1)
    // Run delay of twelve ticks: lamps flash while held
    bus(1'b1, 7'h24, 16'd12);
    run_cmd <= 1'b1;
    cnt = 0;
    n = 0;
    pv = mon[5];
    repeat (100) begin
      @(posedge clk);
      cnt += int'(mon[5] !== pv);
      n += int'(reverse_lamp !== forward_lamp);
      pv = mon[5];
    end
    `CHK(mon[0], 1'b0)
    `CHK(cnt > 0, 1'b1)
    `CHK(n, 0)
    wt(0, 1'b1, 60);
    run_cmd <= 1'b0;
    wt(0, 1'b0, 5);
    local_md <= 1'b1;
    run_cmd <= 1'b1;
    wt(0, 1'b1, 10);
    run_cmd <= 1'b0;
    local_md <= 1'b0;
    wt(0, 1'b0, 5);
    bus(1'b1, 7'h20, 16'd100);
    jog <= 1'b1;
    run_cmd <= 1'b1;
    wt(0, 1'b1, 3);
    run_cmd <= 1'b0;
    jog <= 1'b0;
    wt(0, 1'b0, 5);
    run_cmd <= 1'b1;
    repeat (150) @(posedge clk);
    `CHK(mon[0], 1'b0)
    meas.set_freq <= 16'd80;
    wt(0, 1'b1, 150);
    run_cmd <= 1'b0;
    bus(1'b1, 7'h24, 16'd0);
    bus(1'b1, 7'h20, 16'd400);
    bus(1'b1, 7'h18, 16'd200);
    bus(1'b1, 7'h1c, 16'd20);
    meas.set_freq <= 16'd300;
    run_cmd <= 1'b1;
    wt(0, 1'b1, 10);
    meas.set_freq <= 16'd190;
    repeat (5) @(posedge clk);
    `CHK(mon[0], 1'b1)
    meas.set_freq <= 16'd170;
    wt(0, 1'b0, 5);
    run_cmd <= 1'b0;
    bus(1'b1, 7'h20, 16'd0);
    bus(1'b1, 7'h18, 16'd0);
    meas.set_freq <= 16'd1000;
    run_cmd <= 1'b1;
    wt(0, 1'b1, 10);
    run_cmd <= 1'b0;
    wt(1, 1'b0, 60);
    // Fault outputs and the interrupt
    bus(1'b1, 7'h28, 16'h013f);
    bus(1'b1, 7'h2c, 16'h0200);
    bus(1'b1, 7'h3c, 16'd2);
    bus(1'b1, 7'h54, 16'h0040);
    bus(1'b0, 7'h50, 16'h0000);
    pulse(1'b0, 5'h13, 4'he);
    `CHK(ec, 4'h0)
    `CHK(alarm_out, 1'b1)
    `CHK(mon[2], 1'b1)
    rdc(7'h50, 32'h40);
    `CHK(mon[2], 1'b0)
    bus(1'b1, 7'h54, 16'h0000);
    pulse(1'b0, 5'h13, 4'hf);
    `CHK(ec, 4'h1)
    rdc(7'h4c, 32'h110c);
    repeat (30) @(posedge clk);
    `CHK(ec, 4'h1)
    `CHK(mon[2], 1'b0)
    fault_rst <= 1'b1;
    @(posedge clk);
    fault_rst <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK(ec, 4'h0)
    `CHK(alarm_out, 1'b0)
    pulse(1'b1, 5'h00, 4'h0);
    `CHK(ec, 4'h2)
    wt(4, 1'b0, 40);
    `CHK(n > 8, 1'b1)
    `CHK(alarm_out, 1'b1)
    // Power loss in mid-delay
    run_cmd <= 1'b1;
    wt(1, 1'b1, 20);
    run_cmd <= 1'b0;
    repeat (10) @(posedge clk);
    nrst <= 1'b0;
    @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    `CHK(mon[1], 1'b0)
    finish_test();
  end
endmodule // tb

bind dso_drive_seq_out dso_asserts u_chk (.*);
